// >>> core/eprm_pkg.sv
/*
  Shared constants and types for the one-time-programmable array controller:
  register offsets, bit positions, timing counts and the carrier structs.
  Assumes a 50 MHz core clock and a 16-bit CPU address space.
*/
package eprm_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [15:0] CTL_ADDR  = 16'h000d;
  localparam logic [15:0] OPT_ADDR  = 16'h0fff;
  localparam logic [15:0] ARR_BASE  = 16'h1000;
  localparam logic [15:0] ARR_LAST  = 16'h1eff;
  localparam int          ARR_DEPTH = 3840;
  localparam int          ARR_IW    = 12;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTL_LAT_BIT = 1;
  localparam int          CTL_PRG_BIT = 0;
  localparam logic [7:0]  CTL_RESET   = 8'h00;
  localparam int          OPT_SLOW    = 5;
  localparam int          OPT_SECURE  = 4;
  localparam int          OPT_DLY_HI  = 3;
  localparam int          OPT_DLY_LO  = 1;
  localparam int          OPT_RC      = 0;
  localparam logic [7:0]  ERASED      = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int PROG_TIME_NS    = 1000000;
  localparam int PROG_CYCLES     =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_NORMAL      = 2;
  localparam int DIV_SLOW        = 32;
  localparam int POR_BASE_CYCLES = 256;

  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } eprm_req_t;

  typedef struct packed {
    logic       slow;
    logic       secure;
    logic [2:0] dly;
    logic       osc_rc;
  } eprm_cfg_t;

  typedef enum logic [1:0] {
    PS_IDLE  = 2'b00,
    PS_ARMED = 2'b01,
    PS_BURN  = 2'b10,
    PS_DONE  = 2'b11
  } eprm_prog_t;

endpackage

// >>> core/eprm_div.sv
/*
  Operating tick divider: one tick per instruction cycle.
  Assumes rst_q is the synchronised reset copy of the top module.
*/
`timescale 1ns/10ps
module eprm_div (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_q,
  // control
  input  wire logic slow,
  input  wire logic run,
  // tick out
  output logic      tick
);

  logic [4:0] cnt;
  wire  [4:0] limit = slow ? 5'(eprm_pkg::DIV_SLOW - 1)
                           : 5'(eprm_pkg::DIV_NORMAL - 1);
  wire        wrap  = cnt == limit;

  // ----------------------------------------------------------------
  // divide by 2, or by 32 in slow start
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      cnt  <= 5'h00;
      tick <= 1'b0;
    end else begin
      cnt  <= (!run || wrap) ? 5'h00 : cnt + 5'h01;
      tick <= run && wrap;
    end
  end

  a_slow_period: assert property (@(posedge clock) disable iff (!rst_q)
    slow && tick |=> (!tick)[*8] ##24 tick)
    else $error("slow tick period is not 32 clocks");

endmodule

// >>> core/eprm_por.sv
/*
  Power-on delay counter in instruction cycles, selected by three bits.
  Assumes tick is a one-clock pulse per instruction cycle.
*/
`timescale 1ns/10ps
module eprm_por #(
  parameter int BASE = eprm_pkg::POR_BASE_CYCLES
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_q,
  // control
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic [2:0] sel,
  // status
  output logic            done
);

  logic [15:0] cnt;
  // base doubles for each code step; code 7 is 128 times the base
  wire  [15:0] lim = (16'(BASE) << sel) - 16'h0001;

  // ----------------------------------------------------------------
  // count ticks until the selected delay has passed
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      cnt  <= 16'h0000;
      done <= 1'b0;
    end else if (!start) begin
      cnt  <= 16'h0000;
      done <= 1'b0;
    end else if (tick && !done) begin
      cnt  <= (cnt == lim) ? cnt : cnt + 16'h0001;
      done <= cnt == lim;
    end
  end

  a_por_length: assert property (@(posedge clock) disable iff (!rst_q)
    $rose(done) |-> $past(cnt) == lim && $past(tick))
    else $error("power-on delay ended at wrong count");

endmodule

// >>> core/eprm_ctrl.sv
/*
  Programming controller for the on-chip one-time-programmable array,
  with the program control register and the option byte latches.
  Assumes a CPU port on the same clock: one-cycle strobes, read data
  returned in the following cycle, no wait states.
*/
`timescale 1ns/10ps
module eprm_ctrl #(
  parameter int PROG_CYCLES = eprm_pkg::PROG_CYCLES,
  parameter int POR_BASE    = eprm_pkg::POR_BASE_CYCLES
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst_b,
  // cpu register and array port
  input  wire eprm_pkg::eprm_req_t bus_req,
  output logic [7:0]               bus_rdata,
  // programming supply switch
  output logic                     prog_power,
  // option latches and their valid flag
  output eprm_pkg::eprm_cfg_t      cfg,
  output logic                     cfg_valid,
  // instruction tick and power-on delay status
  output logic                     op_tick,
  output logic                     por_done
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // true for the user array window
  function automatic logic in_array(input logic [15:0] a);
    return (a >= eprm_pkg::ARR_BASE) && (a <= eprm_pkg::ARR_LAST);
  endfunction

  // array word index of a cpu address
  function automatic logic [eprm_pkg::ARR_IW-1:0] arr_idx(
    input logic [15:0] a);
    logic [15:0] d;
    d = a - eprm_pkg::ARR_BASE;
    return d[eprm_pkg::ARR_IW-1:0];
  endfunction

  localparam logic [16:0] PROG_LAST = 17'(PROG_CYCLES - 1);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------

  logic rst_meta;
  logic rst_q;

  // release through two flops so that every flop leaves reset together
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_q    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_q    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------

  logic [7:0]            mem [eprm_pkg::ARR_DEPTH];
  logic [7:0]            opt_cell;
  logic                  latch;
  logic [15:0]           lat_addr;
  logic [7:0]            lat_data;
  logic [16:0]           burn_cnt;
  eprm_pkg::eprm_prog_t  state;
  eprm_pkg::eprm_prog_t  next_state;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------

  // the control register has an address of its own in page zero
  wire hit_ctl  = bus_req.addr == eprm_pkg::CTL_ADDR;
  wire hit_opt  = bus_req.addr == eprm_pkg::OPT_ADDR;
  wire hit_arr  = in_array(bus_req.addr);
  wire hit_cell = hit_arr || hit_opt;

  wire wr_ctl   = bus_req.wr && hit_ctl;
  wire rd_ctl   = bus_req.rd && hit_ctl;
  // a store into the array only lands while the latch bit is set
  wire wr_cell  = bus_req.wr && hit_cell && latch;
  wire rd_cell  = bus_req.rd && hit_cell;

  // ----------------------------------------------------------------
  // program control register
  // ----------------------------------------------------------------

  // unused upper bits of a write are dropped
  wire next_latch = wr_ctl ? bus_req.wdata[eprm_pkg::CTL_LAT_BIT]
                           : latch;
  wire req_prog   = wr_ctl ? bus_req.wdata[eprm_pkg::CTL_PRG_BIT]
                           : prog_power;
  // the program bit can never stand without the latch bit
  wire next_prog  = req_prog && next_latch;
  wire [7:0] ctl_view = {6'h00, latch, prog_power};

  // a write of zero drops both bits in the same edge
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      latch      <= eprm_pkg::CTL_RESET[eprm_pkg::CTL_LAT_BIT];
      prog_power <= eprm_pkg::CTL_RESET[eprm_pkg::CTL_PRG_BIT];
    end else begin
      latch      <= next_latch;
      prog_power <= next_prog;
    end
  end

  // ----------------------------------------------------------------
  // address and data latch for programming
  // ----------------------------------------------------------------

  // outside latch mode the paths serve reads and the latch holds
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      lat_addr <= 16'h0000;
      lat_data <= 8'h00;
    end else if (wr_cell) begin
      lat_addr <= bus_req.addr;
      lat_data <= bus_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // programming sequencer
  // ----------------------------------------------------------------

  wire burn_last = burn_cnt == PROG_LAST;
  // cells are written only after a full pulse of programming power
  wire commit    = (state == eprm_pkg::PS_BURN) && burn_last
                   && prog_power;

  // the pulse is aborted, not committed, if power drops early
  always_comb begin
    next_state = state;
    case (state)
      eprm_pkg::PS_IDLE: begin
        if (wr_cell)
          next_state = eprm_pkg::PS_ARMED;
      end
      eprm_pkg::PS_ARMED: begin
        if (prog_power)
          next_state = eprm_pkg::PS_BURN;
      end
      eprm_pkg::PS_BURN: begin
        if (!prog_power)
          next_state = eprm_pkg::PS_ARMED;
        else if (burn_last)
          next_state = eprm_pkg::PS_DONE;
      end
      eprm_pkg::PS_DONE: begin
        if (wr_cell)
          next_state = eprm_pkg::PS_ARMED;
      end
      default: next_state = eprm_pkg::PS_IDLE;
    endcase
    if (!latch)
      next_state = eprm_pkg::PS_IDLE;
  end

  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q)
      state <= eprm_pkg::PS_IDLE;
    else
      state <= next_state;
  end

  // pulse length counter, cleared whenever the sequencer is not in PS_BURN
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q)
      burn_cnt <= 17'h00000;
    else if (state == eprm_pkg::PS_BURN && prog_power && !burn_last)
      burn_cnt <= burn_cnt + 17'h00001;
    else if (state != eprm_pkg::PS_BURN)
      burn_cnt <= 17'h00000;
  end

  // ----------------------------------------------------------------
  // nonvolatile cells
  // ----------------------------------------------------------------

  // erased cells are zero; programming only ever sets bits
  initial begin
    for (int i = 0; i < eprm_pkg::ARR_DEPTH; i++)
      mem[i] = eprm_pkg::ERASED;
    opt_cell = eprm_pkg::ERASED;
  end

  // no reset here: the cells keep their contents over reset
  always @(posedge clock) begin
    if (commit && lat_addr == eprm_pkg::OPT_ADDR)
      opt_cell <= opt_cell | lat_data;
    else if (commit)
      mem[arr_idx(lat_addr)] <= mem[arr_idx(lat_addr)] | lat_data;
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------

  wire [7:0] cell_rd  = hit_opt ? opt_cell : mem[arr_idx(bus_req.addr)];
  // while latched the array is being programmed and shows nothing
  wire [7:0] cell_vis = latch ? 8'h00 : cell_rd;
  wire [7:0] next_rdata = rd_ctl  ? ctl_view
                        : rd_cell ? cell_vis
                        : 8'h00;

  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q)
      bus_rdata <= 8'h00;
    else
      bus_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // option latches
  // ----------------------------------------------------------------

  // trade-off: taken one edge after release rather than on the edge
  // itself, so the cells never feed an asynchronous load
  wire eprm_pkg::eprm_cfg_t opt_dec = '{
    slow:   opt_cell[eprm_pkg::OPT_SLOW],
    secure: opt_cell[eprm_pkg::OPT_SECURE],
    dly:    opt_cell[eprm_pkg::OPT_DLY_HI:eprm_pkg::OPT_DLY_LO],
    osc_rc: opt_cell[eprm_pkg::OPT_RC]
  };

  // latched once per reset; later programming has no effect until
  // the next reset, so the options cannot change in user mode
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      cfg       <= '0;
      cfg_valid <= 1'b0;
    end else if (!cfg_valid) begin
      cfg       <= opt_dec;
      cfg_valid <= 1'b1;
    end
  end
  // cfg.secure tells the bootstrap logic to refuse readout
  // cfg.osc_rc picks resistor-capacitor when 1, crystal when 0

  // ----------------------------------------------------------------
  // instruction clock and power-on delay
  // ----------------------------------------------------------------

  eprm_div u_div (
    .clock (clock),
    .rst_q (rst_q),
    .slow  (cfg.slow),
    .run   (cfg_valid),
    .tick  (op_tick)
  );

  eprm_por #(
    .BASE  (POR_BASE)
  ) u_por (
    .clock (clock),
    .rst_q (rst_q),
    .tick  (op_tick),
    .start (cfg_valid),
    .sel   (cfg.dly),
    .done  (por_done)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_q);

  // supply-on time, kept only for the pulse-length check; it
  // saturates so that a latch left powered cannot wrap it
  logic [16:0] pwr_run;
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q)
      pwr_run <= 17'h00000;
    else if (!prog_power)
      pwr_run <= 17'h00000;
    else if (pwr_run != 17'h1ffff)
      pwr_run <= pwr_run + 17'h00001;
  end

  a_prog_interlock: assert property (
    prog_power |-> latch)
    else $error("program bit set without latch bit");

  a_clear_both: assert property (
    wr_ctl && !bus_req.wdata[eprm_pkg::CTL_LAT_BIT]
      |=> !latch && !prog_power)
    else $error("clearing latch did not drop both bits");

  a_power_off: assert property (
    wr_ctl && !bus_req.wdata[eprm_pkg::CTL_PRG_BIT]
      |=> !prog_power)
    else $error("program bit survived a clearing write");

  a_capture_pair: assert property (
    wr_cell |=> lat_addr == $past(bus_req.addr)
             && lat_data == $past(bus_req.wdata))
    else $error("latched address or data wrong");

  a_blank_read: assert property (
    rd_cell && latch |=> bus_rdata == 8'h00)
    else $error("array read returned data while latched");

  a_read_path: assert property (
    bus_req.wr && hit_cell && !latch
      |=> $stable(lat_addr) && $stable(lat_data))
    else $error("unlatched write disturbed the latch");

  a_ctl_reserved: assert property (
    rd_ctl |=> bus_rdata[7:2] == 6'h00
            && bus_rdata[1:0] == $past(ctl_view[1:0]))
    else $error("control register read back wrong");

  a_opt_capture: assert property (
    rst_q && !cfg_valid |=> cfg_valid && cfg == $past(opt_dec))
    else $error("options not latched at reset release");

  a_opt_frozen: assert property (
    cfg_valid |=> $stable(cfg) && cfg_valid)
    else $error("options changed after capture");

  a_burn_commit: assert property (
    commit |-> pwr_run > PROG_LAST)
    else $error("cell written before full pulse");

endmodule

// >>> bench/eprm_ctrl_tb.sv
/*
  Self-checking bench for the programming controller: register access,
  byte programming, abort, option latching and power-on delay timing.
  Assumes the controller alone answers the cpu port, with shortened
  programming and delay counts set through its parameters.
*/
`timescale 1ns/10ps
module eprm_ctrl_tb;

  // ----------------------------------------------------------------
  // settings and signals
  // ----------------------------------------------------------------
  localparam int          prog_n  = 20;
  localparam int          por_n   = 2;
  localparam logic [15:0] ctl_reg = 16'h000d;

  logic                clock;
  logic                rst_b;
  eprm_pkg::eprm_req_t bus_req;
  logic [7:0]          bus_rdata;
  logic                prog_power;
  eprm_pkg::eprm_cfg_t cfg;
  logic                cfg_valid;
  logic                op_tick;
  logic                por_done;
  int                  error_cnt;
  int                  n_compared;
  int                  por_cyc;
  int                  gap;

  eprm_ctrl #(
    .PROG_CYCLES (prog_n),
    .POR_BASE    (por_n)
  ) u_eprm_ctrl (
    .clock      (clock),
    .rst_b      (rst_b),
    .bus_req    (bus_req),
    .bus_rdata  (bus_rdata),
    .prog_power (prog_power),
    .cfg        (cfg),
    .cfg_valid  (cfg_valid),
    .op_tick    (op_tick),
    .por_done   (por_done)
  );

  // free-running 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // reporting and compare tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic mismatch(input string msg);
    error_cnt++;
    $display("Error at %0t: %s", $time, msg);
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp,
                      input string msg);
    n_compared++;
    if (got !== exp) begin
      mismatch($sformatf("%s got %h want %h", msg, got, exp));
    end
  endtask

  task automatic cmp1(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      mismatch(msg);
    end
  endtask

  // let the edge's updates land before looking
  task automatic step();
    @(posedge clock);
    #1;
  endtask

  // ----------------------------------------------------------------
  // cpu port cycles: one-cycle strobes, read data in the next cycle
  // ----------------------------------------------------------------
  task automatic wr_bus(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge clock);
    bus_req.wr    <= 1'b0;
    #1;
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [7:0] exp,
                        input string msg);
    @(posedge clock);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clock);
    bus_req.rd   <= 1'b0;
    #1;
    cmp8(bus_rdata, exp, msg);
  endtask

  // latch, write, program, hold for a number of cycles, clear at once
  task automatic program_byte(input logic [15:0] a, input logic [7:0] d,
                              input int hold);
    wr_bus(ctl_reg, 8'h02);
    wr_bus(a, d);
    wr_bus(ctl_reg, 8'h03);
    cmp1(prog_power, 1'b1, "supply not switched on");
    repeat (hold) step();
    wr_bus(ctl_reg, 8'h00);
    cmp1(prog_power, 1'b0, "supply not switched off");
    chk_rd(ctl_reg, 8'h00, "control not cleared");
  endtask

  // reset, then time option latch, power-on delay and tick spacing
  task automatic restart();
    int n;
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    n = 0;
    while (cfg_valid !== 1'b1) begin
      step();
      n++;
      if (n > 10) begin
        mismatch("options never latched");
        report_and_stop();
      end
    end
    por_cyc = 0;
    while (por_done !== 1'b1) begin
      step();
      por_cyc++;
      if (por_cyc > 20000) begin
        mismatch("power-on delay never ends");
        report_and_stop();
      end
    end
    n = 0;
    while (op_tick !== 1'b1) begin
      step();
      n++;
      if (n > 100) begin
        mismatch("no tick");
        report_and_stop();
      end
    end
    gap = 0;
    do begin
      step();
      gap++;
      if (gap > 100) begin
        mismatch("tick stopped");
        report_and_stop();
      end
    end while (op_tick !== 1'b1);
  endtask

  // power-on delay must sit between one tick less one clock under and one tick plus two clocks over its nominal length
  task automatic chk_por(input int ticks, input int period);
    int nom;
    nom = ticks * period;
    cmp1(por_cyc >= nom - period + 1 && por_cyc <= nom + period + 2,
         1'b1, $sformatf("delay %0d cycles, nominal %0d", por_cyc, nom));
    cmp8(gap[7:0], period[7:0], "tick spacing");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    bus_req    = '0;
    rst_b      = 1'b0;
    error_cnt  = 0;
    n_compared = 0;
    por_cyc    = 0;
    gap        = 0;
    restart();
    cmp8({2'b00, cfg}, 8'h00, "erased options");
    chk_por(por_n, 2);
    chk_rd(ctl_reg, 8'h00, "control reset value");
    chk_rd(eprm_pkg::OPT_ADDR, 8'h00, "erased option cell");
    cmp1(prog_power, 1'b0, "supply on after reset");
    // program bit alone is refused, reserved bits never stick
    wr_bus(ctl_reg, 8'hfd);
    cmp1(prog_power, 1'b0, "supply on without latch");
    chk_rd(ctl_reg, 8'h00, "program bit kept unlatched");
    wr_bus(ctl_reg, 8'hfe);
    chk_rd(ctl_reg, 8'h02, "latch bit or reserved bits");
    step();
    cmp8(bus_rdata, 8'h00, "read data held too long");
    chk_rd(16'h1900, 8'h00, "array readable while latched");
    wr_bus(ctl_reg, 8'h00);
    // unlatched writes and unmapped places change nothing
    wr_bus(eprm_pkg::ARR_BASE, 8'hff);
    chk_rd(eprm_pkg::ARR_BASE, 8'h00, "unlatched write stored");
    wr_bus(16'h0020, 8'h55);
    chk_rd(16'h0020, 8'h00, "unmapped place answered");
    // two full program pulses, then a short aborted one
    program_byte(16'h1900, 8'h5a, prog_n + 4);
    chk_rd(16'h1900, 8'h5a, "programmed byte");
    wr_bus(ctl_reg, 8'h02);
    chk_rd(16'h1900, 8'h00, "stored byte shown while latched");
    wr_bus(ctl_reg, 8'h00);
    program_byte(eprm_pkg::ARR_LAST, 8'h81, prog_n + 4);
    chk_rd(eprm_pkg::ARR_LAST, 8'h81, "last array byte");
    program_byte(16'h1a00, 8'h33, 5);
    chk_rd(16'h1a00, 8'h00, "aborted pulse wrote");
    // option cell: no effect until the next reset
    program_byte(eprm_pkg::OPT_ADDR, 8'h17, prog_n + 4);
    cmp8({2'b00, cfg}, 8'h00, "options moved in user mode");
    restart();
    cmp8({2'b00, cfg}, 8'h17, "latched options");
    chk_por(por_n << 3, 2);
    chk_rd(eprm_pkg::OPT_ADDR, 8'h17, "option cell readback");
    chk_rd(16'h1900, 8'h5a, "array lost over reset");
    // add slow start and the longest delay code
    program_byte(eprm_pkg::OPT_ADDR, 8'h28, prog_n + 4);
    restart();
    cmp8({2'b00, cfg}, 8'h3f, "slow options");
    chk_por(por_n << 7, 32);
    report_and_stop();
  end

endmodule
